// ==== hdl/ptr_defines.svh ====
// Constants of the pressure and temperature readout block.
// Assumes a 100 MHz system clock; included by the package and the top module.
// Functional notes
// RULE_01 - Sleep interval nibble, 62.5ms steps, sleep only
// RULE_02 - Busy bit set at start, self-clears
// RULE_03 - Mode 000 temp, 001 press, 010 both
// RULE_04 - Mode 011 repeats combined acquisition each interval
// RULE_05 - Status bit0 done, cleared by read
// RULE_06 - Host polls done before reading results
// RULE_07 - Pressure result bytes at 06, 07, 08
// RULE_08 - Results are signed two's complement
// RULE_09 - Raw pressure select stores uncompensated data
// RULE_10 - Temperature result bytes at 09, 0A
// RULE_11 - Raw temperature select leaves temperature undefined
// RULE_12 - Temperature carries eight fractional bits
// RULE_13 - Match seven address bits, eighth is direction
// RULE_14 - Acknowledge match, else release until start
// RULE_15 - Write: command byte then data, all acknowledged
// RULE_16 - Read: shift bytes MSB first while acknowledged
// RULE_17 - Host nacks last byte, device releases
// RULE_18 - Stop condition returns device to idle
// RULE_19 - Only host drives serial clock
// RULE_20 - Four-wire mode: select, clock, in, out
// RULE_21 - Address 6D floating, 6C pulled high
// RULE_22 - Select high two-wire, driven low four-wire
// RULE_23 - Interrupt pulse at end of measurement
// RULE_24 - Register pointer auto-increments per byte
// RULE_25 - Read: write pointer, repeated start, read
`ifndef PTR_DEFINES_SVH
`define PTR_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define PTR_OFS_PRESS_HIGH 8'h06
`define PTR_OFS_PRESS_MID  8'h07
`define PTR_OFS_PRESS_LOW  8'h08
`define PTR_OFS_TEMP_HIGH  8'h09
`define PTR_OFS_TEMP_LOW   8'h0a
`define PTR_OFS_STATUS     8'h20
`define PTR_OFS_CONTROL    8'h30

// ****************************************
// Field positions and reset values
// ****************************************
`define PTR_CTRL_SLEEP_MSB 7
`define PTR_CTRL_SLEEP_LSB 4
`define PTR_CTRL_BUSY_BIT  3
`define PTR_CTRL_MODE_MSB  2
`define PTR_CTRL_MODE_LSB  0
`define PTR_STAT_DONE_BIT  0
`define PTR_RST_SLEEP      4'h0
`define PTR_RST_MODE       3'h0
`define PTR_RST_RESULT     8'h00

// ****************************************
// Bus addresses
// ****************************************
`define PTR_ADDR_FLOAT 7'h6d
`define PTR_ADDR_HIGH  7'h6c

// ****************************************
// Timing
// ****************************************
`define PTR_CLK_PERIOD_NS     10
`define PTR_SLEEP_UNIT_NS     62500000
`define PTR_SLEEP_UNIT_CYCLES (`PTR_SLEEP_UNIT_NS / `PTR_CLK_PERIOD_NS)
`define PTR_CONV_CYCLES       64

`endif

// ==== hdl/ptr_pkg.sv ====
// Types of the pressure and temperature readout block.
// Assumes ptr_defines.svh is on the include path.
`include "ptr_defines.svh"

package ptr_pkg;

	typedef enum logic [2:0] {
		MODE_TEMP,
		MODE_PRESS,
		MODE_BOTH,
		MODE_SLEEP,
		MODE_OFF4,
		MODE_OFF5,
		MODE_OFF6,
		MODE_OFF7
	} ptr_mode_t;

	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_WRITE,
		BUS_ACK,
		BUS_READ,
		BUS_RACK,
		BUS_IGNORE
	} ptr_bus_t;

	typedef enum logic [1:0] {
		ACQ_IDLE,
		ACQ_PRESS,
		ACQ_TEMP,
		ACQ_WAIT
	} ptr_acq_t;

	typedef struct packed {
		logic signed [23:0] pressure;
		logic signed [15:0] temperature;
		logic [3:0]         sleepCode;
		logic               busy;
		ptr_mode_t          mode;
		logic               done;
	} ptr_regs_t;

	typedef struct packed {
		logic     scl0, scl1, sclPrev;
		logic     sda0, sda1, sdaPrev;
		logic     cs0, cs1, csPrev;
		logic     si0, si1;
		logic     as0, as1;
		ptr_bus_t bus;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] txShift;
		logic [7:0] pointer;
		logic       firstByte;
		logic       isRead;
		logic       sdaOut;
		logic       sdaOe;
		logic       serialOut;
		logic       serialOutOe;
		ptr_acq_t   acq;
		logic [7:0] convCnt;
		logic [31:0] waitCnt;
		logic       intOut;
		ptr_regs_t  regs;
	} ptr_state_t;

endpackage

// ==== hdl/ptr_readout.sv ====
// Digital side of the pressure and temperature sensor: register file,
// acquisition sequencer, two-wire and four-wire serial slave.
// Assumes the converter results arrive on clk_sys; bus pins are asynchronous.
`timescale 1ns/1ps
`include "ptr_defines.svh"

module ptr_readout
	import ptr_pkg::*;
#(
	parameter int unsigned SLEEP_UNIT_CYCLES = `PTR_SLEEP_UNIT_CYCLES,
	parameter int unsigned CONV_CYCLES       = `PTR_CONV_CYCLES
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic               scl,
	input  wire logic               sdaIn,
	output logic                    sdaOut,
	output logic                    sdaOe,
	input  wire logic               chipSelectN,
	input  wire logic               serialIn,
	input  wire logic               serialOutAddrSelect,
	output logic                    serialOut,
	output logic                    serialOutOe,
	input  wire logic               rawPressureSel,
	input  wire logic               rawTempSel,
	input  wire logic signed [23:0] adcPressure,
	input  wire logic signed [23:0] adcPressureRaw,
	input  wire logic signed [15:0] adcTemperature,
	output logic                    measureIrq
);

	// ****************************************
	// Register read decode
	// ****************************************
	function automatic logic [7:0] ptr_reg_read(input logic [7:0] addr, input ptr_regs_t r);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			`PTR_OFS_PRESS_HIGH: v = r.pressure[23:16]; // [RULE_07] [RULE_08]
			`PTR_OFS_PRESS_MID:  v = r.pressure[15:8]; // [RULE_07]
			`PTR_OFS_PRESS_LOW:  v = r.pressure[7:0]; // [RULE_07]
			`PTR_OFS_TEMP_HIGH:  v = r.temperature[15:8]; // [RULE_10]
			`PTR_OFS_TEMP_LOW:   v = r.temperature[7:0]; // [RULE_10]
			`PTR_OFS_STATUS:     v[`PTR_STAT_DONE_BIT] = r.done & ~r.busy; // [RULE_05]
			`PTR_OFS_CONTROL:    v = {r.sleepCode, r.busy, r.mode};
			default:             v = 8'h00;
		endcase
		return v;
	endfunction

	ptr_state_t s;
	ptr_state_t next_s;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic       sclRise;
		logic       sclFall;
		logic       startCond;
		logic       stopCond;
		logic       wrEn;
		logic       rdEn;
		logic [7:0] wrData;
		logic [7:0] rdData;
		logic [6:0] ownAddr;
		logic [31:0] waitLimit;
		next_s = s;
		sclRise = s.scl1 & ~s.sclPrev;
		sclFall = ~s.scl1 & s.sclPrev;
		startCond = s.scl1 & s.sclPrev & s.sdaPrev & ~s.sda1;
		stopCond = s.scl1 & s.sclPrev & ~s.sdaPrev & s.sda1; // [RULE_18]
		wrEn = 1'b0;
		rdEn = 1'b0;
		wrData = s.shift;
		rdData = ptr_reg_read(s.pointer, s.regs);
		ownAddr = s.as1 ? `PTR_ADDR_HIGH : `PTR_ADDR_FLOAT; // [RULE_21]
		waitLimit = 32'(({28'h0, s.regs.sleepCode} + 32'h1) * SLEEP_UNIT_CYCLES); // [RULE_01]

		// Two-flop synchronisers; only the second stage feeds logic
		next_s.scl0 = scl; // [RULE_19]
		next_s.scl1 = s.scl0;
		next_s.sclPrev = s.scl1;
		next_s.sda0 = sdaIn;
		next_s.sda1 = s.sda0;
		next_s.sdaPrev = s.sda1;
		next_s.cs0 = chipSelectN;
		next_s.cs1 = s.cs0;
		next_s.csPrev = s.cs1;
		next_s.si0 = serialIn;
		next_s.si1 = s.si0;
		next_s.as0 = serialOutAddrSelect;
		next_s.as1 = s.as0;
		next_s.sdaOut = 1'b0;
		next_s.intOut = 1'b0;

		// ****************************************
		// Serial slave
		// ****************************************
		if (s.cs1) begin // [RULE_22]
			next_s.serialOutOe = 1'b0;
			if (startCond) begin
				next_s.bus = BUS_ADDR;
				next_s.bitCnt = 4'h0;
				next_s.sdaOe = 1'b0;
				next_s.firstByte = 1'b1;
			end else if (stopCond) begin
				next_s.bus = BUS_IDLE; // [RULE_18]
				next_s.sdaOe = 1'b0;
			end else begin
				unique case (s.bus)
					BUS_ADDR, BUS_WRITE: begin
						if (sclRise) begin
							next_s.shift = {s.shift[6:0], s.sda1};
							next_s.bitCnt = s.bitCnt + 4'h1;
						end else if (sclFall && s.bitCnt == 4'h8) begin
							if (s.bus == BUS_ADDR) begin
								if (s.shift[7:1] == ownAddr) begin // [RULE_13]
									next_s.sdaOe = 1'b1; // [RULE_14]
									next_s.isRead = s.shift[0]; // [RULE_13]
									next_s.bus = BUS_ACK;
								end else begin
									next_s.bus = BUS_IGNORE; // [RULE_14]
								end
							end else begin
								next_s.sdaOe = 1'b1; // [RULE_15]
								next_s.isRead = 1'b0;
								next_s.bus = BUS_ACK;
								if (s.firstByte) begin
									next_s.pointer = s.shift; // [RULE_15] [RULE_25]
									next_s.firstByte = 1'b0;
								end else begin
									wrEn = 1'b1;
								end
							end
						end
					end
					BUS_ACK: begin
						if (sclFall) begin
							next_s.bitCnt = 4'h0;
							if (s.isRead) begin
								rdEn = 1'b1;
								next_s.shift = rdData;
								next_s.sdaOe = ~rdData[7]; // [RULE_16]
								next_s.bitCnt = 4'h1;
								next_s.bus = BUS_READ;
							end else begin
								next_s.sdaOe = 1'b0;
								next_s.bus = BUS_WRITE;
							end
						end
					end
					BUS_READ: begin
						if (sclFall) begin
							if (s.bitCnt == 4'h8) begin
								next_s.sdaOe = 1'b0;
								next_s.bus = BUS_RACK;
							end else begin
								next_s.shift = {s.shift[6:0], 1'b0};
								next_s.sdaOe = ~s.shift[6]; // [RULE_16]
								next_s.bitCnt = s.bitCnt + 4'h1;
							end
						end
					end
					BUS_RACK: begin
						if (sclRise) begin
							next_s.bus = s.sda1 ? BUS_IGNORE : BUS_ACK; // [RULE_17] [RULE_16]
						end
					end
					BUS_IDLE, BUS_IGNORE: begin
						next_s.sdaOe = 1'b0;
					end
				endcase
			end
		end else begin
			// Four-wire mode 0: sample on rise, shift out on fall
			next_s.bus = BUS_IDLE;
			next_s.sdaOe = 1'b0;
			next_s.serialOutOe = 1'b1; // [RULE_20]
			if (s.csPrev) begin
				next_s.firstByte = 1'b1;
				next_s.bitCnt = 4'h0;
				next_s.serialOut = 1'b0;
			end else if (sclRise) begin
				next_s.shift = {s.shift[6:0], s.si1}; // [RULE_20]
				next_s.bitCnt = s.bitCnt + 4'h1;
				if (s.bitCnt == 4'h7) begin
					next_s.bitCnt = 4'h0;
					wrData = {s.shift[6:0], s.si1};
					if (s.firstByte) begin
						next_s.isRead = wrData[7];
						next_s.pointer = {1'b0, wrData[6:0]};
						next_s.firstByte = 1'b0;
					end else if (!s.isRead) begin
						wrEn = 1'b1;
					end
				end
			end else if (sclFall && s.isRead && !s.firstByte) begin
				if (s.bitCnt == 4'h0) begin
					rdEn = 1'b1;
					next_s.txShift = rdData;
					next_s.serialOut = rdData[7];
				end else begin
					next_s.txShift = {s.txShift[6:0], 1'b0};
					next_s.serialOut = s.txShift[6];
				end
			end
		end

		// Pointer steps past every byte read or written
		if (rdEn || wrEn) begin
			next_s.pointer = s.pointer + 8'h01; // [RULE_24]
		end
		// Clear first so a completion in the same cycle still lands
		if (rdEn && s.pointer == `PTR_OFS_STATUS) begin
			next_s.regs.done = 1'b0; // [RULE_05] [RULE_06]
		end

		// ****************************************
		// Acquisition sequencer
		// ****************************************
		unique case (s.acq)
			ACQ_IDLE: begin
			end
			ACQ_PRESS: begin
				next_s.convCnt = s.convCnt + 8'h01;
				if (32'(s.convCnt) == CONV_CYCLES - 1) begin
					next_s.convCnt = 8'h00;
					next_s.regs.pressure = rawPressureSel ? adcPressureRaw : adcPressure; // [RULE_09]
					next_s.acq = (s.regs.mode == MODE_PRESS) ? ACQ_IDLE : ACQ_TEMP; // [RULE_03]
					if (s.regs.mode == MODE_PRESS) begin
						next_s.regs.busy = 1'b0; // [RULE_02]
						next_s.regs.done = 1'b1; // [RULE_05]
						next_s.intOut = 1'b1; // [RULE_23]
					end
				end
			end
			ACQ_TEMP: begin
				next_s.convCnt = s.convCnt + 8'h01;
				if (32'(s.convCnt) == CONV_CYCLES - 1) begin
					next_s.convCnt = 8'h00;
					if (!rawTempSel) begin
						next_s.regs.temperature = adcTemperature; // [RULE_11] [RULE_12] [RULE_08]
					end
					next_s.regs.busy = 1'b0; // [RULE_02]
					next_s.regs.done = 1'b1; // [RULE_05]
					next_s.intOut = 1'b1; // [RULE_23]
					next_s.waitCnt = 32'h0;
					next_s.acq = (s.regs.mode == MODE_SLEEP) ? ACQ_WAIT : ACQ_IDLE; // [RULE_04]
				end
			end
			ACQ_WAIT: begin
				next_s.waitCnt = s.waitCnt + 32'h1;
				if (s.waitCnt == waitLimit - 32'h1) begin
					next_s.acq = ACQ_PRESS; // [RULE_04] [RULE_01]
					next_s.regs.busy = 1'b1; // [RULE_02]
					next_s.regs.done = 1'b0;
				end
			end
		endcase

		// ****************************************
		// Register writes
		// ****************************************
		if (wrEn && s.pointer == `PTR_OFS_CONTROL) begin
			next_s.regs.sleepCode = wrData[`PTR_CTRL_SLEEP_MSB:`PTR_CTRL_SLEEP_LSB]; // [RULE_01]
			next_s.regs.mode = ptr_mode_t'(wrData[`PTR_CTRL_MODE_MSB:`PTR_CTRL_MODE_LSB]);
			next_s.convCnt = 8'h00;
			unique case (ptr_mode_t'(wrData[`PTR_CTRL_MODE_MSB:`PTR_CTRL_MODE_LSB])) // [RULE_03]
				MODE_TEMP: next_s.acq = ACQ_TEMP;
				MODE_PRESS, MODE_BOTH, MODE_SLEEP: next_s.acq = ACQ_PRESS; // [RULE_04]
				MODE_OFF4, MODE_OFF5, MODE_OFF6, MODE_OFF7: next_s.acq = ACQ_IDLE;
			endcase
			next_s.regs.busy = ~wrData[`PTR_CTRL_MODE_MSB]; // [RULE_02]
			next_s.regs.done = 1'b0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.scl0 <= 1'b1;
			s.scl1 <= 1'b1;
			s.sclPrev <= 1'b1;
			s.sda0 <= 1'b1;
			s.sda1 <= 1'b1;
			s.sdaPrev <= 1'b1;
			s.cs0 <= 1'b1;
			s.cs1 <= 1'b1;
			s.csPrev <= 1'b1;
			s.bus <= BUS_IDLE;
			s.acq <= ACQ_IDLE;
			s.firstByte <= 1'b1;
			s.regs.sleepCode <= `PTR_RST_SLEEP;
			s.regs.mode <= ptr_mode_t'(`PTR_RST_MODE);
			s.regs.pressure <= {3{`PTR_RST_RESULT}};
			s.regs.temperature <= {2{`PTR_RST_RESULT}};
		end else begin
			s <= next_s;
		end
	end

	assign sdaOut = s.sdaOut;
	assign sdaOe = s.sdaOe;
	assign serialOut = s.serialOut;
	assign serialOutOe = s.serialOutOe;
	assign measureIrq = s.intOut;

endmodule

// ==== verification/ptr_readout_monitor.sv ====
// Checker on the readout block's data pin, mode pins and interrupt.
// Assumes two-wire traffic whose clock phases last four cycles or more.
`timescale 1ns/1ps

module ptr_readout_monitor (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic chipSelectN,
	input wire logic serialOutOe,
	input wire logic measureIrq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ****************
	// Pin behaviour
	// ****************
	// Device edges lag a host clock fall by the synchroniser depth, never a rise
	sequence s_afterFall;
		!scl && ($past(scl, 2) || $past(scl, 3) || $past(scl, 4) || $past(scl, 5));
	endsequence
	property p_openDrain; sdaOe |-> !sdaOut; endproperty
	property p_driveAfterFall; $rose(sdaOe) |-> s_afterFall; endproperty
	property p_releaseAfterFall; $fell(sdaOe) |-> s_afterFall; endproperty
	property p_bitHold; $rose(sdaOe) |-> sdaOe [*8]; endproperty
	property p_stableHigh; scl && $past(scl) |-> $stable(sdaOe); endproperty
	property p_stopIdle; scl && $rose(sdaIn) |-> ##5 !sdaOe; endproperty
	property p_twoWire; chipSelectN [*4] |-> !serialOutOe; endproperty
	property p_irqPulse; measureIrq |=> !measureIrq [*8]; endproperty
	property p_fourWire; !chipSelectN [*4] |-> serialOutOe; endproperty
	a_openDrain: assert property (p_openDrain) else $error("data pin driven high");
	a_driveAfterFall: assert property (p_driveAfterFall) else $error("drive off clock fall");
	a_releaseAfterFall: assert property (p_releaseAfterFall) else $error("early release");
	a_bitHold: assert property (p_bitHold) else $error("bit too short");
	a_stableHigh: assert property (p_stableHigh) else $error("data moved, clock high");
	a_stopIdle: assert property (p_stopIdle) else $error("driving after stop");
	a_twoWire: assert property (p_twoWire) else $error("four-wire output in two-wire");
	a_irqPulse: assert property (p_irqPulse) else $error("interrupt not a pulse");
	a_fourWire: assert property (p_fourWire) else $error("four-wire output off");
	c_ack: cover property ($rose(sdaOe));
	c_stop: cover property (scl && $rose(sdaIn));
	c_irq: cover property (measureIrq);
	c_fourWire: cover property (!chipSelectN && serialOutOe);
endmodule

bind ptr_readout ptr_readout_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectN(chipSelectN),
	.serialOutOe(serialOutOe), .measureIrq(measureIrq));

// ==== verification/ptr_host_model.sv ====
// Host model: two-wire and four-wire bus master, sole driver of the serial clock.
// Assumes the bench resolves the open-drain data line into sdaLine.
`timescale 1ns/1ps

module ptr_host_model (
	input  wire logic clk_sys,
	input  wire logic sdaLine,
	input  wire logic misoLine,
	output logic      scl,
	output logic      hostSda,
	output logic      chipSelectN,
	output logic      serialIn
);
	// Four cycles a phase: the fastest the device's oversampling accepts
	initial begin
		scl = 1'b1;
		hostSda = 1'b1;
		chipSelectN = 1'b1;
		serialIn = 1'b0;
	end
	task automatic setCs(input logic c);
		repeat (4) @(posedge clk_sys);
		#1;
		chipSelectN = c;
	endtask
	// Mode 0: our bit goes out and the device's bit is taken a phase before each rise
	task automatic spiByte(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			repeat (4) @(posedge clk_sys);
			#1;
			serialIn = d[i];
			q[i] = misoLine;
			setScl(1'b1);
			setScl(1'b0);
		end
	endtask
	task automatic setSda(input logic d);
		repeat (4) @(posedge clk_sys);
		#1;
		hostSda = d;
	endtask
	task automatic setScl(input logic c);
		repeat (4) @(posedge clk_sys);
		#1;
		scl = c;
	endtask
	task automatic startCond();
		setSda(1'b1);
		setScl(1'b1);
		setSda(1'b0);
		setScl(1'b0);
	endtask
	task automatic stopCond();
		setSda(1'b0);
		setScl(1'b1);
		setSda(1'b1);
	endtask
	// Reads pass d = ff so the line is free; ackIn high on the last read byte
	task automatic byteIo(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
		output logic ackOut);
		for (int i = 8; i >= 0; i--) begin
			setSda((i == 0) ? ackIn : d[i - 1]);
			setScl(1'b1);
			setScl(1'b0);
			if (i == 0) ackOut = sdaLine;
			else q[i - 1] = sdaLine;
		end
	endtask
endmodule

// ==== verification/tb_pressure_temp_readout_i2c.sv ====
// Bench for the readout block: register traffic over the two-wire and four-wire buses.
// Assumes converter inputs stay still while an acquisition runs.
`timescale 1ns/1ps

module tb_pressure_temp_readout_i2c;
	logic               clk_sys;
	logic               rst_n;
	logic               addrSel;
	logic               rawPressureSel;
	logic signed [23:0] adcPressure;
	logic signed [23:0] adcPressureRaw;
	logic signed [15:0] adcTemperature;
	logic               scl;
	logic               hostSda;
	logic               sdaOe;
	logic               measureIrq;
	logic               chipSelectN;
	logic               serialIn;
	logic               serialOut;
	logic               serialOutOe;
	logic               ack;
	logic [6:0]         devAddr;
	logic [7:0]         rd [5];
	logic [23:0]        expP;
	logic [15:0]        expT;
	int                 bad_count;
	int                 samples_checked;
	int                 n;
	int                 gap [2];
	wire                sdaLine = hostSda & ~sdaOe;
	// A deselected output shows the inverse, so a late or stale sample shows up
	wire                misoLine = serialOutOe ? serialOut : ~serialOut;

	ptr_readout #(.SLEEP_UNIT_CYCLES(20), .CONV_CYCLES(255)) i_dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .scl(scl), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
		.chipSelectN(chipSelectN), .serialIn(serialIn), .serialOutAddrSelect(addrSel),
		.serialOut(serialOut), .serialOutOe(serialOutOe),
		.rawPressureSel(rawPressureSel), .rawTempSel(1'b0),
		.adcPressure(adcPressure), .adcPressureRaw(adcPressureRaw),
		.adcTemperature(adcTemperature), .measureIrq(measureIrq));
	ptr_host_model i_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .misoLine(misoLine),
		.scl(scl), .hostSda(hostSda), .chipSelectN(chipSelectN), .serialIn(serialIn));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Pointer write, then (for reads) a repeated start and a burst ended by a nack
	task automatic access(input logic rw, input logic [7:0] ofs, input logic [7:0] val, input int cnt);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		i_host.startCond();
		i_host.byteIo({devAddr, 1'b0}, 1'b1, q, a0);
		i_host.byteIo(ofs, 1'b1, q, a1);
		if (rw) i_host.startCond();
		i_host.byteIo(rw ? {devAddr, 1'b1} : val, 1'b1, q, ack);
		for (int i = 0; i < cnt; i++) begin
			i_host.byteIo(8'hff, i == cnt - 1, rd[i], q[0]);
		end
		i_host.stopCond();
		check(24'({a0, a1, ack}), 24'h000000, "acks");
	endtask
	// Four-wire frame: command byte {read, offset[6:0]}, then cnt bytes read or one written
	task automatic access4(input logic [7:0] cmd, input logic [7:0] val, input int cnt);
		logic [7:0] q;
		i_host.setScl(1'b0);
		i_host.setCs(1'b0);
		i_host.spiByte(cmd, q);
		if (!cmd[7]) i_host.spiByte(val, q);
		for (int i = 0; i < cnt; i++) begin
			i_host.spiByte(8'h00, rd[i]);
		end
		i_host.setCs(1'b1);
		i_host.setScl(1'b1);
	endtask
	task automatic waitIrq(output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_sys);
			#1;
			cnt++;
		end while (measureIrq !== 1'b1 && cnt < 2000);
		if (cnt >= 2000) begin
			bad_count++;
			$display("[FAIL] %0t interrupt timeout", $time);
			conclude();
		end
	endtask

	initial begin
		bad_count = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		addrSel = 1'b0;
		rawPressureSel = 1'b0;
		adcPressure = 24'h812345;
		adcPressureRaw = 24'h7abcde;
		adcTemperature = 16'h0000;
		devAddr = 7'h6d;
		repeat (3) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		access(1'b1, 8'h06, 8'h00, 5);
		for (int i = 0; i < 5; i++) check(24'(rd[i]), 24'h000000, "reset result");
		access(1'b1, 8'h30, 8'h00, 1);
		check(24'(rd[0]), 24'h000000, "reset control");
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			addrSel = i[1];
			i_host.startCond();
			i_host.byteIo({i[0] ? 7'h6c : 7'h6d, 1'b0}, 1'b1, rd[0], ack);
			i_host.stopCond();
			check(24'(ack), 24'(i[0] ^ i[1]), "address answer");
		end
		addrSel = 1'b0;
		$display("address test done");
		expP = 24'h000000;
		for (int m = 0; m < 3; m++) begin
			rawPressureSel = (m == 1);
			adcTemperature = 16'hf3a0 + 16'(m);
			if (m != 0) expP = (m == 1) ? adcPressureRaw : adcPressure;
			if (m != 1) expT = adcTemperature;
			access(1'b0, 8'h30, 8'(m), 0);
			access(1'b1, 8'h30, 8'h00, 1);
			check(24'(rd[0]), 24'({4'h0, m == 2, 3'(m)}), "busy bit");
			n = 0;
			do begin
				access(1'b1, 8'h20, 8'h00, 1);
				n++;
			end while (rd[0][0] !== 1'b1 && n < 20);
			check(24'(n < 20), 24'h000001, "done seen");
			access(1'b1, 8'h20, 8'h00, 1);
			check(24'(rd[0][0]), 24'h000000, "done cleared");
			access(1'b1, 8'h06, 8'h00, 5);
			check({rd[0], rd[1], rd[2]}, expP, "pressure");
			check(24'({rd[3], rd[4]}), 24'(expT), "temperature");
		end
		$display("mode test done");
		access4(8'h86, 8'h00, 5);
		check({rd[0], rd[1], rd[2]}, expP, "four-wire pressure");
		check(24'({rd[3], rd[4]}), 24'(expT), "four-wire temperature");
		access4(8'h30, 8'h05, 0);
		access(1'b1, 8'h30, 8'h00, 1);
		check(24'(rd[0]), 24'h000005, "four-wire write");
		$display("four-wire test done");
		for (int k = 0; k < 2; k++) begin
			access(1'b0, 8'h30, {(k == 0) ? 4'h0 : 4'hf, 4'h3}, 0);
			waitIrq(n);
			waitIrq(gap[k]);
		end
		check(24'(gap[0] >= 530 && gap[0] <= 545), 24'h000001, "sleep period");
		check(24'(gap[1] - gap[0]), 24'h00012c, "sleep code step");
		access(1'b0, 8'h30, 8'h04, 0);
		n = 0;
		repeat (1500) begin
			@(posedge clk_sys);
			#1;
			if (measureIrq === 1'b1) n++;
		end
		check(24'(n), 24'h000000, "stopped");
		$display("sleep test done");
		conclude();
	end
endmodule
